// ---- sfw_checker.sv ----
// Port checks for the command decoder and write protection.
// Assumes a bind onto sfw_spi_cmd_protect; one clk_sys domain, rst high.
`timescale 1ns/1ps
`default_nettype none

module sfw_checker (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Pins
    input wire logic cs_n,
    input wire logic so_oe,
    // Reports and store
    input wire logic [2:0] nv_status_out,
    input wire logic nv_status_wr,
    input wire logic cmd_valid,
    input var sfw_pkg::sfw_cmd_type cmd_code,
    input wire logic cmd_write_ok,
    input wire logic array_wr,
    input wire logic [sfw_pkg::ADDR_W-1:0] array_wr_addr,
    input wire logic [7:0] status_view
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Write command kinds and the array range left open by the protect field
    logic wr_kind;
    logic addr_ok;
    assign wr_kind = cmd_code inside {sfw_pkg::status_write_cmd, sfw_pkg::array_write_cmd,
        sfw_pkg::special_sector_write_cmd, sfw_pkg::serial_number_write_cmd};
    assign addr_ok = (status_view[3:2] == 2'h0) || (status_view[3:2] == 2'h1 && array_wr_addr < 20'hc0000)
        || (status_view[3:2] == 2'h2 && array_wr_addr < 20'h80000);

    property p_valid_pulse;
        cmd_valid |=> !cmd_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("command report held too long");
    property p_ok_kind;
        cmd_valid && !wr_kind |-> !cmd_write_ok;
    endproperty
    a_ok_kind: assert property (p_ok_kind)
        else $error("write permission on a non-write command");
    property p_fixed_bits;
        status_view[6] && status_view[5:4] == 2'h0;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("fixed status bits wrong");
    property p_nv_mirror;
        nv_status_out == {status_view[7], status_view[3:2]};
    endproperty
    a_nv_mirror: assert property (p_nv_mirror)
        else $error("store copy differs from status view");
    property p_status_wr_ok;
        nv_status_wr |-> cmd_code == sfw_pkg::status_write_cmd && cmd_write_ok;
    endproperty
    a_status_wr_ok: assert property (p_status_wr_ok)
        else $error("status stored without permission");
    property p_array_wr_ok;
        array_wr |-> cmd_code == sfw_pkg::array_write_cmd && cmd_write_ok;
    endproperty
    a_array_wr_ok: assert property (p_array_wr_ok)
        else $error("array written without permission");
    property p_array_range;
        array_wr |-> addr_ok;
    endproperty
    a_array_range: assert property (p_array_range)
        else $error("array written inside protected range");
    property p_so_idle;
        cs_n [*8] |-> !so_oe;
    endproperty
    a_so_idle: assert property (p_so_idle)
        else $error("serial output driven while deselected");

    // Main scenarios
    c_status_wr: cover property (nv_status_wr);
    c_array_wr: cover property (array_wr);
    c_refused: cover property (cmd_valid ##1 wr_kind && !cmd_write_ok);
endmodule

`default_nettype wire

// ---- sfw_pkg.sv ----
// Constants and types shared by the serial memory command decoder and protection logic.
// Assumes a single system clock; all SPI pins arrive asynchronously and are synchronised.
package sfw_pkg;

    // Command opcodes
    localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OPC_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
    localparam logic [7:0] OPC_FAST_ARRAY_READ = 8'h0b;
    localparam logic [7:0] OPC_SPECIAL_SECTOR_WRITE = 8'h42;
    localparam logic [7:0] OPC_SPECIAL_SECTOR_READ = 8'h4b;
    localparam logic [7:0] OPC_IDENTITY_READ = 8'h9f;
    localparam logic [7:0] OPC_UNIQUE_ID_READ = 8'h4c;
    localparam logic [7:0] OPC_SERIAL_NUMBER_WRITE = 8'hc2;
    localparam logic [7:0] OPC_SERIAL_NUMBER_READ = 8'hc3;
    localparam logic [7:0] OPC_DEEP_SLEEP = 8'hba;
    localparam logic [7:0] OPC_HIBERNATE = 8'hb9;

    // Decoded commands; cmd_none stands for every reserved opcode
    typedef enum logic [3:0] {
        cmd_none = 4'h0,
        set_write_latch_cmd = 4'h1,
        clear_write_latch_cmd = 4'h2,
        status_read_cmd = 4'h3,
        status_write_cmd = 4'h4,
        array_write_cmd = 4'h5,
        array_read_cmd = 4'h6,
        fast_array_read_cmd = 4'h7,
        special_sector_write_cmd = 4'h8,
        special_sector_read_cmd = 4'h9,
        identity_read_cmd = 4'ha,
        unique_identifier_read_cmd = 4'hb,
        serial_number_write_cmd = 4'hc,
        serial_number_read_cmd = 4'hd,
        deep_sleep_cmd = 4'he,
        hibernate_cmd = 4'hf
    } sfw_cmd_type;

    // Status register bit positions
    localparam int ST_PIN_ENABLE_BIT = 7;
    localparam int ST_FIXED_ONE_BIT = 6;
    localparam int ST_BLOCK_PROTECT_1_BIT = 3;
    localparam int ST_BLOCK_PROTECT_0_BIT = 2;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_BUSY_BIT = 0;

    // Values after reset
    localparam logic LATCH_RESET = 1'b0;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic PIN_ENABLE_RESET = 1'b0;
    localparam logic [7:0] STATUS_VIEW_RESET = 8'h40;
    localparam logic [3:0] PIN_SYNC_RESET = 4'h9;

    // Array geometry and protection boundaries
    localparam int ADDR_W = 20;
    localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
    localparam logic [19:0] PROTECT_QUARTER_BASE = 20'hc0000;
    localparam logic [19:0] PROTECT_HALF_BASE = 20'h80000;
    localparam logic [2:0] LAST_BIT = 3'h7;

endpackage

// ---- sfw_spi_cmd_protect.sv ----
// Opcode decoder, write-enable latch, status register and write gating of an SPI memory slave.
// Assumes the SPI pins are asynchronous to clk_sys and much slower than it; the array itself,
// nonvolatile storage and the read, identity and low-power data phases live outside.
`timescale 1ns/1ps
`default_nettype none

module sfw_spi_cmd_protect (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // SPI pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // Nonvolatile protect store
    input wire logic [2:0] nv_status_in,
    output logic [2:0] nv_status_out,
    output logic nv_status_wr,
    // Wake-up indication from the power block
    input wire logic wake_busy,
    // Command report
    output logic cmd_valid,
    output var sfw_pkg::sfw_cmd_type cmd_code,
    output logic cmd_write_ok,
    // Array write port
    output logic array_wr,
    output logic [sfw_pkg::ADDR_W-1:0] array_wr_addr,
    output logic [7:0] array_wr_data,
    // Status view
    output logic [7:0] status_view
);

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_opcode = 3'h1,
        st_addr = 3'h3,
        st_array_data = 3'h2,
        st_status_data = 3'h6,
        st_status_out = 3'h7,
        st_hold = 3'h5,
        st_ignore = 3'h4
    } sfw_state_type;

    // Map an opcode to its command, reserved values to cmd_none
    function automatic sfw_pkg::sfw_cmd_type decode_opcode(input logic [7:0] opc);
        sfw_pkg::sfw_cmd_type c;
        c = sfw_pkg::cmd_none;
        case (opc)
            sfw_pkg::OPC_SET_WRITE_LATCH: c = sfw_pkg::set_write_latch_cmd;
            sfw_pkg::OPC_CLEAR_WRITE_LATCH: c = sfw_pkg::clear_write_latch_cmd;
            sfw_pkg::OPC_STATUS_READ: c = sfw_pkg::status_read_cmd;
            sfw_pkg::OPC_STATUS_WRITE: c = sfw_pkg::status_write_cmd;
            sfw_pkg::OPC_ARRAY_WRITE: c = sfw_pkg::array_write_cmd;
            sfw_pkg::OPC_ARRAY_READ: c = sfw_pkg::array_read_cmd;
            sfw_pkg::OPC_FAST_ARRAY_READ: c = sfw_pkg::fast_array_read_cmd;
            sfw_pkg::OPC_SPECIAL_SECTOR_WRITE: c = sfw_pkg::special_sector_write_cmd;
            sfw_pkg::OPC_SPECIAL_SECTOR_READ: c = sfw_pkg::special_sector_read_cmd;
            sfw_pkg::OPC_IDENTITY_READ: c = sfw_pkg::identity_read_cmd;
            sfw_pkg::OPC_UNIQUE_ID_READ: c = sfw_pkg::unique_identifier_read_cmd;
            sfw_pkg::OPC_SERIAL_NUMBER_WRITE: c = sfw_pkg::serial_number_write_cmd;
            sfw_pkg::OPC_SERIAL_NUMBER_READ: c = sfw_pkg::serial_number_read_cmd;
            sfw_pkg::OPC_DEEP_SLEEP: c = sfw_pkg::deep_sleep_cmd;
            sfw_pkg::OPC_HIBERNATE: c = sfw_pkg::hibernate_cmd;
            default: c = sfw_pkg::cmd_none;
        endcase
        return c;
    endfunction

    // Commands that need the latch and clear it when select is released
    function automatic logic is_latched_write(input sfw_pkg::sfw_cmd_type c);
        logic r;
        r = 1'b0;
        case (c)
            sfw_pkg::status_write_cmd,
            sfw_pkg::array_write_cmd,
            sfw_pkg::special_sector_write_cmd,
            sfw_pkg::serial_number_write_cmd: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Address falls inside the range selected by the protect field
    function automatic logic addr_protected(input logic [1:0] bp, input logic [sfw_pkg::ADDR_W-1:0] a);
        logic r;
        r = 1'b0;
        case (bp)
            2'h1: r = (a >= sfw_pkg::PROTECT_QUARTER_BASE);
            2'h2: r = (a >= sfw_pkg::PROTECT_HALF_BASE);
            2'h3: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Assemble the status byte with its fixed bits
    function automatic logic [7:0] build_status(input logic pen, input logic [1:0] bp, input logic latch,
                                                input logic busy);
        logic [7:0] s;
        s = 8'h00;
        s[sfw_pkg::ST_PIN_ENABLE_BIT] = pen;
        s[sfw_pkg::ST_FIXED_ONE_BIT] = 1'b1;
        s[sfw_pkg::ST_BLOCK_PROTECT_1_BIT] = bp[1];
        s[sfw_pkg::ST_BLOCK_PROTECT_0_BIT] = bp[0];
        s[sfw_pkg::ST_LATCH_BIT] = latch;
        s[sfw_pkg::ST_BUSY_BIT] = busy;
        return s;
    endfunction

    logic [3:0] pin_sync;
    logic cs_f;
    logic sck_f;
    logic si_f;
    logic wp_f;
    logic cs_prev_reg;
    logic sck_prev_reg;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    sfw_state_type state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_in_reg;
    logic [7:0] rx_byte;
    logic byte_done;
    sfw_pkg::sfw_cmd_type rx_cmd;
    logic [1:0] byte_cnt_reg;
    logic [sfw_pkg::ADDR_W-1:0] addr_reg;
    logic latch_reg;
    logic clear_pending_reg;
    logic pin_enable_reg;
    logic [1:0] bp_reg;
    logic nv_loaded_reg;
    logic [7:0] shift_out_reg;
    logic [2:0] out_cnt_reg;
    logic [7:0] status_now;
    logic status_guarded;
    logic opcode_done;
    logic data_protected;

    // Pin synchronisers: cs_n, sck, si, wp_n
    sfw_sync3 #(
        .WIDTH(4),
        .RESET_VAL(sfw_pkg::PIN_SYNC_RESET)
    ) i_sfw_sync3 (
        .clk_sys(clk_sys),
        .rst(rst),
        .d_in({cs_n, sck, si, wp_n}),
        .q_out(pin_sync)
    );

    // Filtered pin levels and edges
    assign cs_f = pin_sync[3];
    assign sck_f = pin_sync[2];
    assign si_f = pin_sync[1];
    assign wp_f = pin_sync[0];
    assign cs_fall = cs_prev_reg && !cs_f;
    assign cs_rise = !cs_prev_reg && cs_f;
    assign sck_rise = !sck_prev_reg && sck_f && !cs_f;
    assign sck_fall = sck_prev_reg && !sck_f && !cs_f;

    // Received byte with the current bit, MSB first
    assign rx_byte = {shift_in_reg[6:0], si_f};
    assign byte_done = sck_rise && (bit_cnt_reg == sfw_pkg::LAST_BIT);
    assign rx_cmd = decode_opcode(rx_byte);
    assign opcode_done = byte_done && (state_reg == st_opcode);
    assign status_now = build_status(pin_enable_reg, bp_reg, latch_reg, wake_busy);
    assign status_guarded = pin_enable_reg && !wp_f;
    assign data_protected = addr_protected(bp_reg, addr_reg);

    // Edge history
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cs_prev_reg <= 1'b1;
            sck_prev_reg <= 1'b0;
        end
        else
        begin
            cs_prev_reg <= cs_f;
            sck_prev_reg <= sck_f;
        end
    end

    // Bit counter and input shifter, restarted on each selection
    always_ff @(posedge clk_sys)
    begin
        if (rst || cs_fall)
        begin
            bit_cnt_reg <= 3'h0;
            shift_in_reg <= 8'h00;
        end
        else if (sck_rise)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_in_reg <= rx_byte;
        end
    end

    // Command sequencer
    always_ff @(posedge clk_sys)
    begin
        if (rst || cs_f)
        begin
            state_reg <= st_idle;
        end
        else if (cs_fall)
        begin
            state_reg <= st_opcode;
        end
        else if (byte_done)
        begin
            case (state_reg)
                st_opcode:
                begin
                    case (rx_cmd)
                        sfw_pkg::cmd_none: state_reg <= st_ignore;
                        sfw_pkg::status_read_cmd: state_reg <= st_status_out;
                        sfw_pkg::status_write_cmd: state_reg <= (latch_reg && !status_guarded) ?
                            st_status_data : st_hold;
                        sfw_pkg::array_write_cmd: state_reg <= latch_reg ? st_addr : st_hold;
                        default: state_reg <= st_hold;
                    endcase
                end
                st_addr:
                begin
                    if (byte_cnt_reg == sfw_pkg::ADDR_LAST_BYTE)
                    begin
                        state_reg <= st_array_data;
                    end
                end
                st_array_data:
                begin
                    if (data_protected)
                    begin
                        state_reg <= st_hold;
                    end
                end
                st_status_data: state_reg <= st_hold;
                default: state_reg <= state_reg;
            endcase
        end
    end

    // Address collection and burst increment
    always_ff @(posedge clk_sys)
    begin
        if (rst || cs_fall)
        begin
            byte_cnt_reg <= 2'h0;
            addr_reg <= '0;
        end
        else if (byte_done && state_reg == st_addr)
        begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            addr_reg <= {addr_reg[sfw_pkg::ADDR_W-9:0], rx_byte};
        end
        else if (byte_done && state_reg == st_array_data && !data_protected)
        begin
            addr_reg <= addr_reg + 20'h00001;
        end
    end

    // Array write strobe, blocked in protected ranges
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            array_wr <= 1'b0;
            array_wr_addr <= '0;
            array_wr_data <= 8'h00;
        end
        else
        begin
            array_wr <= byte_done && state_reg == st_array_data && !data_protected;
            if (byte_done && state_reg == st_array_data && !data_protected)
            begin
                array_wr_addr <= addr_reg;
                array_wr_data <= rx_byte;
            end
        end
    end

    // Write-enable latch
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            latch_reg <= sfw_pkg::LATCH_RESET;
        end
        else if (opcode_done && rx_cmd == sfw_pkg::set_write_latch_cmd)
        begin
            latch_reg <= 1'b1;
        end
        else if (cs_rise && clear_pending_reg)
        begin
            latch_reg <= 1'b0;
        end
    end

    // Marks a command that clears the latch at select release
    always_ff @(posedge clk_sys)
    begin
        if (rst || cs_fall)
        begin
            clear_pending_reg <= 1'b0;
        end
        else if (opcode_done && (rx_cmd == sfw_pkg::clear_write_latch_cmd || is_latched_write(rx_cmd)))
        begin
            clear_pending_reg <= 1'b1;
        end
    end

    // Protect bits: taken from the store after reset, updated by a status write
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_enable_reg <= sfw_pkg::PIN_ENABLE_RESET;
            bp_reg <= sfw_pkg::BP_RESET;
            nv_loaded_reg <= 1'b0;
            nv_status_wr <= 1'b0;
        end
        else if (!nv_loaded_reg)
        begin
            pin_enable_reg <= nv_status_in[2];
            bp_reg <= nv_status_in[1:0];
            nv_loaded_reg <= 1'b1;
            nv_status_wr <= 1'b0;
        end
        else
        begin
            nv_status_wr <= byte_done && state_reg == st_status_data;
            if (byte_done && state_reg == st_status_data)
            begin
                pin_enable_reg <= rx_byte[sfw_pkg::ST_PIN_ENABLE_BIT];
                bp_reg <= {rx_byte[sfw_pkg::ST_BLOCK_PROTECT_1_BIT], rx_byte[sfw_pkg::ST_BLOCK_PROTECT_0_BIT]};
            end
        end
    end

    // Copy of the stored bits for the nonvolatile store
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            nv_status_out <= {sfw_pkg::PIN_ENABLE_RESET, sfw_pkg::BP_RESET};
        end
        else
        begin
            nv_status_out <= {pin_enable_reg, bp_reg};
        end
    end

    // Status read output, driven on falling edges, repeats while selected
    always_ff @(posedge clk_sys)
    begin
        if (rst || cs_f)
        begin
            so <= 1'b0;
            so_oe <= 1'b0;
            shift_out_reg <= 8'h00;
            out_cnt_reg <= 3'h0;
        end
        else if (opcode_done)
        begin
            shift_out_reg <= status_now;
            out_cnt_reg <= 3'h0;
        end
        else if (sck_fall && state_reg == st_status_out)
        begin
            so <= shift_out_reg[7];
            so_oe <= 1'b1;
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (out_cnt_reg == sfw_pkg::LAST_BIT)
            begin
                shift_out_reg <= status_now;
            end
            else
            begin
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            end
        end
    end

    // Command report with its permission
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cmd_valid <= 1'b0;
            cmd_code <= sfw_pkg::cmd_none;
            cmd_write_ok <= 1'b0;
        end
        else
        begin
            cmd_valid <= opcode_done && rx_cmd != sfw_pkg::cmd_none;
            if (opcode_done)
            begin
                cmd_code <= rx_cmd;
                if (rx_cmd == sfw_pkg::status_write_cmd)
                begin
                    cmd_write_ok <= latch_reg && !status_guarded;
                end
                else
                begin
                    cmd_write_ok <= latch_reg && is_latched_write(rx_cmd);
                end
            end
        end
    end

    // Registered status view
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            status_view <= sfw_pkg::STATUS_VIEW_RESET;
        end
        else
        begin
            status_view <= status_now;
        end
    end

endmodule

`default_nettype wire

// ---- sfw_spi_cmd_protect_test.sv ----
// Self-checking bench for the command decoder and write protection.
// Assumes the master model drives the SPI pins; side inputs come from here.
`timescale 1ns/1ps
`default_nettype none

module sfw_spi_cmd_protect_test;
    // Clock, reset and side inputs
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic wake_busy = 1'b0;
    logic [2:0] nv_status_in = 3'h1;
    wire logic cs_n, sck, si;
    logic so, so_oe, cmd_valid, cmd_write_ok, array_wr, nv_status_wr;
    logic [2:0] nv_status_out;
    logic [19:0] array_wr_addr;
    logic [7:0] array_wr_data, status_view, rx;
    sfw_pkg::sfw_cmd_type cmd_code;
    logic [27:0] wq[$];
    int mismatches = 0;
    int checks = 0;
    int nvalid = 0;
    logic [7:0] ops[15] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0b, 8'h42,
        8'h4b, 8'h9f, 8'h4c, 8'hc2, 8'hc3, 8'hba, 8'hb9};

    always #12.5 clk_sys = ~clk_sys;

    sfw_spi_master i_sfw_spi_master (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
    sfw_spi_cmd_protect i_sfw_spi_cmd_protect (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck),
        .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .nv_status_in(nv_status_in),
        .nv_status_out(nv_status_out), .nv_status_wr(nv_status_wr), .wake_busy(wake_busy),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write_ok(cmd_write_ok), .array_wr(array_wr),
        .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data), .status_view(status_view));

    // Count reports and collect array writes
    always @(posedge clk_sys)
    begin
        if (cmd_valid === 1'b1)
            nvalid++;
        if (array_wr === 1'b1)
            wq.push_back({array_wr_addr, array_wr_data});
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One frame of n bytes, lowest n bytes of b, first byte highest
    task automatic send(input logic [47:0] b, input int n);
        i_sfw_spi_master.sel();
        for (int k = n - 1; k >= 0; k--)
            i_sfw_spi_master.xfer(b[8*k+:8], rx);
        i_sfw_spi_master.desel();
    endtask

    task automatic rd(input logic [7:0] e);
        send(48'h0500, 2);
        chk_byte(rx, e);
        chk_byte(status_view, e);
    endtask

    task automatic status_write(input logic [7:0] v);
        send(48'h06, 1);
        send({40'h01, v}, 2);
    endtask

    task automatic pins(input logic w, input logic b);
        @(posedge clk_sys);
        #1;
        wp_n = w;
        wake_busy = b;
    endtask

    task automatic t_latch();
        rd(8'h44);
        send(48'h06, 1);
        rd(8'h46);
        send(48'h04, 1);
        rd(8'h44);
        pins(1'b1, 1'b1);
        rd(8'h45);
        pins(1'b1, 1'b0);
        i_sfw_spi_master.idle_hi = 1'b1;
        rd(8'h44);
        i_sfw_spi_master.idle_hi = 1'b0;
    endtask

    task automatic t_status();
        status_write(8'hff);
        chk_val(cmd_write_ok, 1);
        rd(8'hcc);
        chk_val(nv_status_out, 3'h7);
        send(48'h0100, 2);
        chk_val(cmd_write_ok, 0);
        rd(8'hcc);
        pins(1'b0, 1'b0);
        status_write(8'h00);
        chk_val(cmd_write_ok, 0);
        rd(8'hcc);
        pins(1'b1, 1'b0);
        status_write(8'h84);
        rd(8'hc4);
    endtask

    task automatic t_array();
        pins(1'b0, 1'b0);
        wq.delete();
        send(48'h06, 1);
        send(48'h021bffff1122, 6);
        chk_val(wq.size(), 1);
        chk_val(wq[0], {20'hbffff, 8'h11});
        pins(1'b1, 1'b0);
        status_write(8'h00);
        pins(1'b0, 1'b0);
        status_write(8'h08);
        rd(8'h48);
        status_write(8'h00);
        wq.delete();
        send(48'h06, 1);
        send(48'h020fffffa55a, 6);
        send(48'h0200000077, 5);
        chk_val(wq.size(), 2);
        chk_val(wq[1], {20'h00000, 8'h5a});
    endtask

    task automatic t_decode();
        int n0;
        for (int i = 0; i < 15; i++)
        begin
            n0 = nvalid;
            send({40'h0, ops[i]}, 1);
            chk_val(nvalid, n0 + 1);
            chk_val(cmd_code, i + 1);
        end
        n0 = nvalid;
        send(48'hff0500, 3);
        chk_byte(rx, 8'h00);
        chk_val(nvalid, n0);
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        t_latch();
        t_status();
        t_array();
        t_decode();
        complete_run();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        #1000000;
        mismatches++;
        complete_run();
    end
endmodule

bind sfw_spi_cmd_protect sfw_checker i_sfw_checker (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n),
    .so_oe(so_oe), .nv_status_out(nv_status_out), .nv_status_wr(nv_status_wr), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_write_ok(cmd_write_ok), .array_wr(array_wr),
    .array_wr_addr(array_wr_addr), .status_view(status_view));

`default_nettype wire

// ---- sfw_spi_master.sv ----
// SPI master model, mode 0 or mode 3, with a 200 ns serial clock.
// Assumes the bench calls its tasks; clock stands still outside frames.
`timescale 1ns/1ps
`default_nettype none

module sfw_spi_master (
    // SPI pins
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    // Clock rest level: low for mode 0, high for mode 3
    logic idle_hi = 1'b0;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // Select opens a frame with the clock at rest; the first byte is the opcode
    task automatic sel();
        sck = idle_hi;
        #200;
        cs_n = 1'b0;
        #200;
    endtask

    // Release flips the data line so no stale bit lingers
    task automatic desel();
        #200;
        cs_n = 1'b1;
        si = ~si;
        #400;
    endtask

    // One byte MSB first; output read late in the high phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'b0;
            si = tx[i];
            #100 sck = 1'b1;
            #100 rx[i] = so & so_oe;
        end
        sck = idle_hi;
    endtask
endmodule

`default_nettype wire

// ---- sfw_sync3.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs come from outside clk_sys; output updates when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module sfw_sync3 #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // Synchroniser chain; stage one is read only by stage two
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
        end
        else
        begin
            stage1_reg <= d_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Accept a new level per bit once two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q_out <= RESET_VAL;
        end
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2_reg[i] == stage3_reg[i])
                begin
                    q_out[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule

`default_nettype wire
